//--- port_out_regs.vh
/*
  constants for the port-output execution unit: opcode fields, cycle
  figures and pointer steps.
  assumes it is included by bare name from the design files only.
*/
`ifndef PORT_OUT_REGS_VH
`define PORT_OUT_REGS_VH

// ----------------------------------------------------------------
// opcode fields
// ----------------------------------------------------------------
`define OP_BLOCK_HI      7'h1D
`define OP_REG_IND_HI    7'h1F
`define LO_INC_REPEAT    3'h1
`define LO_DEC_ANY       3'h5
`define LO_DIRECT        3'h3
`define LO2_REPEAT       4'h0
`define LO2_SINGLE       4'h8

// ----------------------------------------------------------------
// cycle figures
// ----------------------------------------------------------------
`define CYC_BLOCK_BASE   8'h0B
`define CYC_BLOCK_ELEM   8'h0A
`define CYC_SINGLE_MEM   8'h15
`define CYC_OUT_IND      8'h0A
`define CYC_OUT_DIR      8'h0C
`define CYC_INT_EXTRA    8'h07

// ----------------------------------------------------------------
// pointer steps and reset values
// ----------------------------------------------------------------
`define STEP_BYTE        16'h0001
`define STEP_WORD        16'h0002
`define RST_WORD         16'h0000

`endif

//--- port_out_decode.v
/*
  combinational decoder of the two-word port-output instructions.
  assumes both opcode words are stable while i_start is high.
*/
`timescale 1ns/1ps
`default_nettype none
`include "port_out_regs.vh"

module port_out_decode
(
  // opcode words
  input  wire [15:0] i_word0,
  input  wire [15:0] i_word1,
  // decoded kind
  output reg         o_is_block,    // memory-to-port, repeating
  output reg         o_is_single,   // memory-to-port, single, decrement
  output reg         o_is_reg_ind,  // register to port, indirect
  output reg         o_is_reg_dir,  // register to port, direct
  output wire        o_inc,         // increment pointer
  output wire        o_byte,        // byte size
  output wire        o_special,     // special i/o space
  output wire [3:0]  o_src,         // source field
  output wire [3:0]  o_cnt,         // count register field
  output wire [3:0]  o_port         // port register field
);

  // field taps shared by every form
  assign o_byte    = ~i_word0[8];
  assign o_special = i_word0[0];
  assign o_src     = i_word0[7:4];
  assign o_cnt     = i_word1[11:8];
  assign o_port    = (i_word0[15:9] == `OP_REG_IND_HI) ? i_word0[7:4]
                                                        : i_word1[7:4];
  assign o_inc     = (i_word0[3:1] == `LO_INC_REPEAT);

  // ----------------------------------------------------------------
  // form decode
  // ----------------------------------------------------------------
  always @*
  begin
    o_is_block   = 1'b0;
    o_is_single  = 1'b0;
    o_is_reg_ind = 1'b0;
    o_is_reg_dir = 1'b0;
    if (i_word0[15:9] == `OP_BLOCK_HI)
    begin
      // memory forms need a nonzero pointer and port register
      if (((i_word0[3:1] == `LO_INC_REPEAT) ||
           (i_word0[3:1] == `LO_DEC_ANY)) &&
          (i_word0[7:4] != 4'h0) && (i_word1[15:12] == 4'h0) &&
          (i_word1[7:4] != 4'h0))
      begin
        if (i_word1[3:0] == `LO2_REPEAT)
          o_is_block = 1'b1;
        else if ((i_word1[3:0] == `LO2_SINGLE) &&
                 (i_word0[3:1] == `LO_DEC_ANY))
          o_is_single = 1'b1;
      end
      else if (i_word0[3:1] == `LO_DIRECT)
        o_is_reg_dir = 1'b1;
    end
    else if ((i_word0[15:9] == `OP_REG_IND_HI) && (i_word0[7:4] != 4'h0))
      // indirect form is standard space only
      o_is_reg_ind = 1'b1;
  end

endmodule // port_out_decode
`default_nettype wire

//--- port_out_pointer.v
/*
  pointer stepper: next source address after one element.
  assumes the caller registers the result.
*/
`timescale 1ns/1ps
`default_nettype none
`include "port_out_regs.vh"

module port_out_pointer
(
  // current pointer and step control
  input  wire [15:0] i_ptr,
  input  wire        i_inc,
  input  wire        i_byte,
  // stepped pointer
  output wire [15:0] o_ptr
);

  wire [15:0] step;  // element size in bytes

  assign step  = i_byte ? `STEP_BYTE : `STEP_WORD;
  // offset wraps inside its segment, segment never changes
  assign o_ptr = i_inc ? (i_ptr + step) : (i_ptr - step);

endmodule // port_out_pointer
`default_nettype wire

//--- port_out_exec.v
/*
  execution unit for the port-output instructions of a 16-bit core.
  holds a small register file view (16 word registers plus segment
  words), fetches elements from memory and writes them to i/o ports.
  assumes memory answers a read one cycle after o_mem_rd and that the
  port write is taken in the cycle o_io_wr is high.
*/
// Chosen here: the plain strobed port and the register addresses.
// Behaviour
// - element read from pointer, written to port
// - increment variant steps pointer 1 or 2
// - decrement variants step pointer down 1 or 2
// - count decremented each element, repeat until zero
// - port address register never modified
// - 1..65536 elements, words as well as bytes
// - interrupts taken between elements, start pc saved
// - each interrupt adds seven cycles
// - block takes eleven plus ten per element
// - block end sets overflow, clears zero flag
// - single decrement sets overflow on zero count
// - pointer is word or segment plus offset
// - space bit selects special or standard i/o
// - increment-repeat opcode layout
// - decrement-repeat opcode layout
// - indirect register output, ten cycles
// - direct register output, twelve cycles
// - register outputs keep all flags
// - special space not available to indirect register output
`timescale 1ns/1ps
`default_nettype none
`include "port_out_regs.vh"

module port_out_exec
(
  // clock and reset
  input  wire        i_clk_sys,
  input  wire        i_rst_n,
  // instruction issue
  input  wire        i_start,        // one-cycle issue pulse
  input  wire [15:0] i_word0,
  input  wire [15:0] i_word1,
  input  wire [15:0] i_start_pc,     // address of the instruction
  input  wire        i_segmented,    // segmented addressing mode
  input  wire        i_irq,          // interrupt request level
  // register file load port
  input  wire        i_reg_wr,
  input  wire [3:0]  i_reg_idx,
  input  wire [15:0] i_reg_data,
  input  wire [6:0]  i_seg_data,     // segment of a pair
  // memory read answer
  input  wire [15:0] i_mem_data,
  // status
  output reg         o_busy,
  output reg         o_done,         // one-cycle end pulse
  output reg         o_irq_ack,      // interrupt taken pulse
  output reg  [15:0] o_saved_pc,
  output reg         o_flag_v,
  output reg         o_flag_z,
  output reg  [7:0]  o_cycles,       // cycles charged so far
  // memory read request
  output reg         o_mem_rd,
  output reg  [22:0] o_mem_addr,     // segment & offset
  output reg         o_mem_byte,
  // i/o write
  output reg         o_io_wr,
  output reg         o_io_special,
  output reg  [15:0] o_io_addr,
  output reg  [15:0] o_io_data,
  output reg         o_io_byte,
  // register read back
  output reg  [15:0] o_reg_rd_data
);

  // ----------------------------------------------------------------
  // states
  // ----------------------------------------------------------------
  localparam [4:0] ST_IDLE  = 5'h01;
  localparam [4:0] ST_READ  = 5'h02;
  localparam [4:0] ST_WRITE = 5'h04;
  localparam [4:0] ST_WAIT  = 5'h08;
  localparam [4:0] ST_IRQ   = 5'h10;

  // cycle budget, counted from the issue edge (o_cycles is 1 there):
  //   memory forms wait, strobe the read, let the answer cycle pass,
  //   then write the port. a block writes its first element in cycle
  //   13, every later one 10 cycles after the one before, and spends
  //   8 cycles after the last write, so n elements end at 11 + 10n.
  //   the single decrement form takes 21 cycles in all.
  //   register forms wait out 10 or 12 cycles with no memory access.
  //   an interrupt at a boundary spends 7 cycles, then goes idle
  //   without done so that the core restarts from o_saved_pc.
  // trade-off: one shared countdown keeps the unit small, at the
  // cost of a less obvious mapping from state to cycle figure; each
  // preload below is the figure minus the fixed edges around it.

  // ----------------------------------------------------------------
  // storage
  // ----------------------------------------------------------------
  reg  [15:0] regs_ff [0:15];   // word registers
  reg  [6:0]  segs_ff [0:15];   // segment word of each pair
  reg  [4:0]  state_ff;
  reg  [7:0]  wait_ff;          // cycles left in this phase
  reg         inc_ff;
  reg         byte_ff;
  reg         block_ff;
  reg  [3:0]  src_ff;
  reg  [3:0]  cnt_ff;
  // no read-data latch: the element is taken in the write cycle

  // decode outputs
  wire        is_block;
  wire        is_single;
  wire        is_reg_ind;
  wire        is_reg_dir;
  wire        dec_inc;
  wire        dec_byte;
  wire        dec_special;
  wire [3:0]  dec_src;
  wire [3:0]  dec_cnt;
  wire [3:0]  dec_port;
  wire [15:0] nxt_ptr;
  wire [15:0] nxt_cnt;
  wire [3:0]  ptr_idx;

  port_out_decode u_decode
  (
    .i_word0      (i_word0),
    .i_word1      (i_word1),
    .o_is_block   (is_block),
    .o_is_single  (is_single),
    .o_is_reg_ind (is_reg_ind),
    .o_is_reg_dir (is_reg_dir),
    .o_inc        (dec_inc),
    .o_byte       (dec_byte),
    .o_special    (dec_special),
    .o_src        (dec_src),
    .o_cnt        (dec_cnt),
    .o_port       (dec_port)
  );

  // segmented mode uses the odd word of the pair as the offset
  assign ptr_idx = i_segmented ? (src_ff | 4'h1) : src_ff;

  port_out_pointer u_pointer
  (
    .i_ptr  (regs_ff[ptr_idx]),
    .i_inc  (inc_ff),
    .i_byte (byte_ff),
    .o_ptr  (nxt_ptr)
  );

  assign nxt_cnt = regs_ff[cnt_ff] - 16'h0001;

  // ----------------------------------------------------------------
  // register file: loads from outside, updates from execution
  // ----------------------------------------------------------------
  genvar gi;
  generate
    for (gi = 0; gi < 16; gi = gi + 1)
    begin : g_regs
      always @(posedge i_clk_sys)
      begin
        if (!i_rst_n)
        begin
          regs_ff[gi] <= `RST_WORD;
          segs_ff[gi] <= 7'h00;
        end
        else if ((state_ff == ST_WRITE) && (gi == ptr_idx))
          // pointer moves; the port register is never written here
          regs_ff[gi] <= nxt_ptr;
        else if ((state_ff == ST_WRITE) && (gi == cnt_ff))
          regs_ff[gi] <= nxt_cnt;
        else if (i_reg_wr && (i_reg_idx == gi))
        begin
          regs_ff[gi] <= i_reg_data;
          segs_ff[gi] <= i_seg_data;
        end
      end
    end
  endgenerate

  // ----------------------------------------------------------------
  // sequencer
  // ----------------------------------------------------------------
  always @(posedge i_clk_sys)
  begin
    if (!i_rst_n)
    begin
      state_ff      <= ST_IDLE;
      wait_ff       <= 8'h00;
      inc_ff        <= 1'b0;
      byte_ff       <= 1'b0;
      block_ff      <= 1'b0;
      src_ff        <= 4'h0;
      cnt_ff        <= 4'h0;
      o_busy        <= 1'b0;
      o_done        <= 1'b0;
      o_irq_ack     <= 1'b0;
      o_saved_pc    <= 16'h0000;
      o_flag_v      <= 1'b0;
      o_flag_z      <= 1'b0;
      o_cycles      <= 8'h00;
      o_mem_rd      <= 1'b0;
      o_mem_addr    <= 23'h00_0000;
      o_mem_byte    <= 1'b0;
      o_io_wr       <= 1'b0;
      o_io_special  <= 1'b0;
      o_io_addr     <= 16'h0000;
      o_io_data     <= 16'h0000;
      o_io_byte     <= 1'b0;
      o_reg_rd_data <= 16'h0000;
    end
    else
    begin
      // pulses default low
      o_done        <= 1'b0;
      o_irq_ack     <= 1'b0;
      o_mem_rd      <= 1'b0;
      o_io_wr       <= 1'b0;
      o_reg_rd_data <= regs_ff[i_reg_idx];
      if (state_ff != ST_IDLE)
        o_cycles <= o_cycles + 8'h01;
      case (state_ff)
        ST_IDLE:
        begin
          if (i_start && (is_block || is_single))
          begin
            inc_ff     <= dec_inc;
            byte_ff    <= dec_byte;
            block_ff   <= is_block;
            src_ff     <= dec_src;
            cnt_ff     <= dec_cnt;
            o_io_special <= dec_special;
            o_io_addr  <= regs_ff[dec_port];
            o_saved_pc <= i_start_pc;
            o_busy     <= 1'b1;
            o_cycles   <= 8'h01;
            // fixed overhead spent before the first element
            wait_ff    <= is_block ? (`CYC_BLOCK_BASE - 8'h02)
                                   : (`CYC_SINGLE_MEM - 8'h05);
            state_ff   <= ST_WAIT;
          end
          else if (i_start && (is_reg_ind || is_reg_dir))
          begin
            // register forms: flags untouched
            o_io_special <= is_reg_dir & dec_special;
            o_io_addr  <= is_reg_dir ? i_word1 : regs_ff[dec_port];
            o_io_data  <= is_reg_dir ? regs_ff[dec_src]
                                     : regs_ff[i_word0[3:0]];
            o_io_byte  <= dec_byte;
            o_io_wr    <= 1'b1;
            o_busy     <= 1'b1;
            o_cycles   <= 8'h01;
            block_ff   <= 1'b0;
            src_ff     <= 4'h0;
            wait_ff    <= is_reg_dir ? (`CYC_OUT_DIR - 8'h02)
                                     : (`CYC_OUT_IND - 8'h02);
            state_ff   <= ST_IRQ;
          end
        end
        ST_WAIT:
        begin
          if (wait_ff == 8'h00)
          begin
            // fetch the element at the pointer
            o_mem_rd   <= 1'b1;
            o_mem_addr <= {i_segmented ? segs_ff[src_ff & 4'hE]
                                       : 7'h00, regs_ff[ptr_idx]};
            o_mem_byte <= byte_ff;
            state_ff   <= ST_READ;
          end
          else
            wait_ff <= wait_ff - 8'h01;
        end
        ST_READ:
        begin
          // memory drives its answer only in the cycle after the
          // strobe, so the element goes straight into the port write
          state_ff    <= ST_WRITE;
        end
        ST_WRITE:
        begin
          o_io_data <= i_mem_data;
          o_io_byte <= byte_ff;
          o_io_wr   <= 1'b1;
          // count 0 wraps to ffff and so moves 65536 elements
          if (block_ff && (nxt_cnt != 16'h0000))
          begin
            // interrupts are only taken at this element boundary
            if (i_irq)
            begin
              o_irq_ack <= 1'b1;
              wait_ff   <= `CYC_INT_EXTRA - 8'h01;
              state_ff  <= ST_IRQ;
            end
            else
            begin
              wait_ff  <= `CYC_BLOCK_ELEM - 8'h03;
              state_ff <= ST_WAIT;
            end
          end
          else
          begin
            // block ends with v set; single reports zero count
            o_flag_v <= block_ff ? 1'b1 : (nxt_cnt == 16'h0000);
            o_flag_z <= 1'b0;
            wait_ff  <= block_ff ? (`CYC_BLOCK_ELEM - 8'h03) : 8'h00;
            src_ff   <= 4'h0;
            state_ff <= ST_IRQ;
          end
        end
        ST_IRQ:
        begin
          // shared countdown: interrupt service penalty or tail time
          if (wait_ff == 8'h00)
          begin
            // every form ends here. an interrupted block still holds
            // its source field, so it stops without done; pointer and
            // count are already advanced, the port register untouched,
            // and the core reissues the instruction from o_saved_pc.
            // resuming inside the unit instead would hide the request
            // from the core that has to service it.
            o_busy   <= 1'b0;
            o_done   <= (src_ff == 4'h0);
            state_ff <= ST_IDLE;
          end
          else
            wait_ff <= wait_ff - 8'h01;
        end
        default:
          state_ff <= ST_IDLE;
      endcase
    end
  end

endmodule // port_out_exec
`default_nettype wire

//--- port_out_exec_properties.sv
/*
  assertion checker for port_out_exec.
  assumes it sees only the unit's ports, bound from below.
*/
`timescale 1ns/1ps
`default_nettype none
module port_out_exec_chk
(
  // clock and reset
  input wire        i_clk_sys,
  input wire        i_rst_n,
  // issue
  input wire        i_start,
  input wire [15:0] i_word0,
  input wire [15:0] i_word1,
  input wire [15:0] i_start_pc,
  // status
  input wire        o_busy,
  input wire        o_done,
  input wire        o_irq_ack,
  input wire [15:0] o_saved_pc,
  input wire        o_flag_v,
  input wire [7:0]  o_cycles,
  // memory and port
  input wire        o_mem_rd,
  input wire [22:0] o_mem_addr,
  input wire        o_mem_byte,
  input wire        o_io_wr,
  input wire        o_io_special,
  input wire [15:0] o_io_addr
);
  // --------
  // issue tracking
  // --------
  reg  [15:0] w0, w1, pc_c;     // opcode words and pc of this issue
  reg  [15:0] last_rd, last_io; // previous read and port address
  reg  [7:0]  n_wr;             // port writes since issue
  reg         had_rd, had_wr;   // an earlier element exists
  wire        blk  = w0[15:9] == 7'h1D && w1[3:0] == 4'h0 &&
                     (w0[3:1] == 3'h1 || w0[3:1] == 3'h5);
  wire        ind  = w0[15:9] == 7'h1F;
  wire        dir  = w0[15:9] == 7'h1D && w0[3:1] == 3'h3;
  wire        inc  = w0[3:1] == 3'h1;
  wire [15:0] step = o_mem_byte ? 16'h0001 : 16'h0002;

  // restart at each accepted issue so a resumed block counts afresh
  always @(posedge i_clk_sys)
  begin
    if (!i_rst_n || (i_start && !o_busy))
    begin
      w0     <= i_word0;
      w1     <= i_word1;
      pc_c   <= i_start_pc;
      n_wr   <= 8'h00;
      had_rd <= 1'b0;
      had_wr <= 1'b0;
    end
    else
    begin
      n_wr   <= n_wr + {7'h00, o_io_wr};
      had_rd <= had_rd | o_mem_rd;
      had_wr <= had_wr | o_io_wr;
    end
    if (o_mem_rd)
      last_rd <= o_mem_addr[15:0];
    if (o_io_wr)
      last_io <= o_io_addr;
  end

  // --------
  // properties
  // --------
  default clocking cb @(posedge i_clk_sys);
  endclocking
  default disable iff (!i_rst_n);

  rd_then_wr_a: assert property (o_mem_rd |-> ##2 o_io_wr)
    else $error("element read not followed by port write");
  ptr_step_a: assert property (o_mem_rd && had_rd |->
    o_mem_addr[15:0] == (inc ? last_rd + step : last_rd - step))
    else $error("source pointer stepped wrongly");
  port_hold_a: assert property (o_io_wr && had_wr |->
    o_io_addr == last_io)
    else $error("port address moved within a block");
  blk_cycles_a: assert property (o_done && blk |->
    o_cycles == 8'd11 + 8'd10 * n_wr)
    else $error("block cycle total wrong");
  blk_flag_a: assert property (o_done && blk |-> o_flag_v)
    else $error("overflow not set after block");
  ind_cycles_a: assert property (o_done && ind |-> o_cycles == 8'd10)
    else $error("indirect output cycle total wrong");
  dir_cycles_a: assert property (o_done && dir |-> o_cycles == 8'd12)
    else $error("direct output cycle total wrong");
  reg_flags_a: assert property (o_busy && (ind || dir) |=>
    $stable(o_flag_v))
    else $error("register output touched a flag");
  space_sel_a: assert property (o_io_wr |->
    o_io_special == (w0[15:9] == 7'h1D && w0[0]))
    else $error("i/o space select wrong");
  irq_pc_a: assert property (o_irq_ack |-> o_saved_pc == pc_c)
    else $error("saved pc is not the start pc");
  irq_cost_a: assert property (o_irq_ack |-> ##6 o_busy ##1 !o_busy)
    else $error("interrupt did not cost seven cycles");
  done_pulse_a: assert property (o_done |=> !o_done)
    else $error("done longer than one cycle");
endmodule // port_out_exec_chk

bind port_out_exec port_out_exec_chk u_chk
(
  .i_clk_sys, .i_rst_n, .i_start, .i_word0, .i_word1, .i_start_pc,
  .o_busy, .o_done, .o_irq_ack, .o_saved_pc, .o_flag_v, .o_cycles,
  .o_mem_rd, .o_mem_addr, .o_mem_byte, .o_io_wr, .o_io_special,
  .o_io_addr
);
`default_nettype wire

//--- port_out_far.sv
/*
  memory and i/o peripheral model facing the port-output unit.
  assumes a read is answered in the cycle after its strobe.
*/
`timescale 1ns/1ps
`default_nettype none
module port_out_far
(
  // clock
  input  wire         i_clk_sys,
  // memory read
  input  wire         i_rd,
  input  wire  [22:0] i_addr,
  output logic [15:0] o_data,
  // port write
  input  wire         i_wr,
  input  wire  [15:0] i_wr_addr,
  input  wire  [15:0] i_wr_data
);
  // --------
  // logs read by the bench
  // --------
  logic [22:0] ra_q[$]; // read addresses
  logic [15:0] wa_q[$]; // port addresses
  logic [15:0] wd_q[$]; // port data

  initial o_data = 16'h0000;

  // data only in the answer cycle; toggles otherwise so stale data fails
  always @(posedge i_clk_sys)
  begin
    o_data <= i_rd ? (i_addr[15:0] ^ 16'h5a3c) : ~o_data;
    if (i_rd)
      ra_q.push_back(i_addr);
    if (i_wr)
      wa_q.push_back(i_wr_addr);
    if (i_wr)
      wd_q.push_back(i_wr_data);
  end
endmodule // port_out_far
`default_nettype wire

//--- tb_top.sv
/*
  self-checking bench for port_out_exec.
  assumes the memory model answers reads one cycle later.
*/
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  // --------
  // stimulus and wires
  // --------
  logic        i_clk_sys = 1'b0;
  logic        i_rst_n = 1'b0;
  logic        i_start = 1'b0;
  logic [15:0] i_word0 = 16'h0000;
  logic [15:0] i_word1 = 16'h0000;
  logic [15:0] i_start_pc = 16'h0000;
  logic        i_segmented = 1'b0;
  logic        i_irq = 1'b0;
  logic        i_reg_wr = 1'b0;
  logic [3:0]  i_reg_idx = 4'h0;
  logic [15:0] i_reg_data = 16'h0000;
  logic [6:0]  i_seg_data = 7'h12; // every pair uses this segment
  wire  [15:0] i_mem_data;
  wire         o_busy, o_done, o_irq_ack, o_flag_v, o_flag_z;
  wire         o_mem_rd, o_mem_byte, o_io_wr, o_io_special, o_io_byte;
  wire  [15:0] o_saved_pc, o_io_addr, o_io_data, o_reg_rd_data;
  wire  [7:0]  o_cycles;
  wire  [22:0] o_mem_addr;
  int          failures = 0;
  int          checks = 0;
  logic        ack;      // last issue ended by an interrupt
  logic [15:0] rv;       // register read back

  port_out_exec uut (.i_clk_sys, .i_rst_n, .i_start, .i_word0,
    .i_word1, .i_start_pc, .i_segmented, .i_irq, .i_reg_wr, .i_reg_idx,
    .i_reg_data, .i_seg_data, .i_mem_data, .o_busy, .o_done, .o_irq_ack,
    .o_saved_pc, .o_flag_v, .o_flag_z, .o_cycles, .o_mem_rd, .o_mem_addr,
    .o_mem_byte, .o_io_wr, .o_io_special, .o_io_addr, .o_io_data,
    .o_io_byte, .o_reg_rd_data);
  port_out_far mdl (.i_clk_sys, .i_rd(o_mem_rd), .i_addr(o_mem_addr),
    .o_data(i_mem_data), .i_wr(o_io_wr), .i_wr_addr(o_io_addr),
    .i_wr_data(o_io_data));

  always #4 i_clk_sys = ~i_clk_sys;

  // --------
  // shared tasks
  // --------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp)
    begin
      failures++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic results;
    if (failures == 0 && checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge i_clk_sys);
    i_reg_wr <= 1'b1;
    i_reg_idx <= a;
    i_reg_data <= d;
    @(posedge i_clk_sys);
    i_reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a);
    @(posedge i_clk_sys);
    i_reg_idx <= a;
    repeat (2) @(posedge i_clk_sys);
    #1 rv = o_reg_rd_data;
  endtask
  // issue, then wait bounded for done or an interrupt hand-off
  task automatic go(input logic [15:0] a, input logic [15:0] b,
                    input logic [15:0] pc);
    int k;
    mdl.ra_q.delete();
    mdl.wa_q.delete();
    mdl.wd_q.delete();
    // an interrupted block is still winding down
    wait (o_busy !== 1'b1);
    @(posedge i_clk_sys);
    i_start <= 1'b1;
    i_word0 <= a;
    i_word1 <= b;
    i_start_pc <= pc;
    @(posedge i_clk_sys);
    i_start <= 1'b0;
    for (k = 0; k < 3000; k++)
    begin
      #1;
      if (o_done === 1'b1 || o_irq_ack === 1'b1)
        break;
      @(posedge i_clk_sys);
    end
    if (k == 3000)
      failures++;
    ack = o_irq_ack;
  endtask

  // --------
  // scenarios
  // --------
  task automatic s_reg;
    wr(4'h2, 16'h1120);
    wr(4'h3, 16'h5252);
    go(16'h3f23, 16'h0000, 16'h0100);
    chk(o_io_addr, 16'h1120);
    chk(o_io_data, 16'h5252);
    chk(o_io_special, 1'b0);
    for (int s = 0; s < 2; s++)
    begin
      go({15'h1d9b, s[0]}, 16'h0030, 16'h0104);
      chk(o_io_addr, 16'h0030);
      chk(o_io_special, s[0]);
    end
    @(posedge i_clk_sys);
    i_start <= 1'b1;
    i_word0 <= 16'h0000;
    @(posedge i_clk_sys);
    i_start <= 1'b0;
    #1 chk(o_busy, 1'b0);
  endtask
  task automatic s_dec;
    wr(4'hb, 16'h0fff);
    wr(4'hc, 16'hb006);
    wr(4'hd, 16'h0006);
    go(16'h3bca, 16'h0db0, 16'h0200);
    chk(mdl.wa_q.size(), 6);
    for (int i = 0; i < 6; i++)
    begin
      chk(mdl.wa_q[i], 16'h0fff);
      chk(mdl.wd_q[i], (16'hb006 - 2 * i) ^ 16'h5a3c);
    end
    chk(o_flag_v, 1'b1);
    chk(o_cycles, 8'h47);
    rd(4'hc);
    chk(rv, 16'haffa);
    rd(4'hd);
    chk(rv, 16'h0000);
    rd(4'hb);
    chk(rv, 16'h0fff);
  endtask
  task automatic s_inc;
    wr(4'h1, 16'h0040);
    wr(4'h2, 16'h2000);
    wr(4'h3, 16'h0003);
    go(16'h3a23, 16'h0310, 16'h0300);
    for (int i = 0; i < 3; i++)
      chk(mdl.ra_q[i][15:0], 16'h2000 + i);
    chk(o_io_special, 1'b1);
    chk(o_io_byte, 1'b1);
    chk(o_mem_byte, 1'b1);
    rd(4'h2);
    chk(rv, 16'h2003);
  endtask
  task automatic s_seg;
    @(posedge i_clk_sys);
    i_segmented <= 1'b1;
    wr(4'h2, 16'h0060);
    wr(4'h6, 16'h0012);
    wr(4'h7, 16'h5552);
    wr(4'h8, 16'h0002);
    go(16'h3b62, 16'h0820, 16'h0400);
    chk(mdl.ra_q[0], 23'h12_5552);
    chk(mdl.ra_q[1], 23'h12_5554);
    chk(mdl.wd_q[1], 16'h5554 ^ 16'h5a3c);
    @(posedge i_clk_sys);
    i_segmented <= 1'b0;
  endtask
  task automatic s_one;
    wr(4'hc, 16'h4000);
    wr(4'hd, 16'h0002);
    go(16'h3bca, 16'h0db8, 16'h0500);
    chk(mdl.wa_q.size(), 1);
    chk(o_flag_v, 1'b0);
    chk(o_cycles, 8'h15);
    rd(4'hc);
    chk(rv, 16'h3ffe);
    go(16'h3bca, 16'h0db8, 16'h0500);
    chk(o_flag_v, 1'b1);
    rd(4'hd);
    chk(rv, 16'h0000);
  endtask
  // interrupt held during a block, then the same pc issued again
  task automatic s_irq;
    int n;
    wr(4'h1, 16'h0050);
    wr(4'h2, 16'h3000);
    wr(4'h3, 16'h0004);
    @(posedge i_clk_sys);
    i_irq <= 1'b1;
    go(16'h3b22, 16'h0310, 16'h0600);
    chk(ack, 1'b1);
    chk(o_saved_pc, 16'h0600);
    @(posedge i_clk_sys);
    i_irq <= 1'b0;
    // the write of the interrupted element is logged at this edge
    #1 n = mdl.wa_q.size();
    chk(n, 1);
    go(16'h3b22, 16'h0310, 16'h0600);
    chk(n + mdl.wa_q.size(), 4);
    rd(4'h2);
    chk(rv, 16'h3008);
    rd(4'h3);
    chk(rv, 16'h0000);
  endtask

  // --------
  // run
  // --------
  initial
  begin
    repeat (6) @(posedge i_clk_sys);
    i_rst_n <= 1'b1;
    s_reg;
    s_dec;
    s_inc;
    s_seg;
    s_one;
    s_irq;
    results;
  end
  // the whole run needs a few hundred cycles
  initial
  begin
    #400000;
    failures++;
    results;
  end
endmodule // tb_top
`default_nettype wire
